// [src/pdc_pkg.sv]
// constants shared by the test-counter and delay-line register slice
// assumes the importer runs everything on one clock with synchronous reset
package pdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus geometry: printed offsets are word indices, byte address is 4x
    localparam int ADR_W = 10;
    localparam int REG_W = 16;
    localparam int DLY_W = 12;

    localparam logic [7:0] IDX_ERR_CNT = 8'h72;
    localparam logic [7:0] IDX_PKT_LEN = 8'h7B;
    localparam logic [7:0] IDX_GAP_LEN = 8'h7C;
    localparam logic [7:0] IDX_DLL_CTRL = 8'h86;
    localparam logic [7:0] IDX_PLL_RSVD = 8'hC6;
    localparam logic [7:0] IDX_SWING = 8'hD6;
    localparam logic [7:0] IDX_HYB_RSVD = 8'hE9;
    localparam logic [7:0] IDX_MODE = 8'hF0;
    localparam logic [7:0] IDX_BYTE_SNAP = 8'hF1;
    localparam logic [7:0] IDX_PKT_SNAP = 8'hF2;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [15:0] RST_PKT_LEN = 16'h05DC;
    localparam logic [7:0] RST_GAP_LEN = 8'h7D;
    localparam logic [9:0] RST_DLL_CTRL = 10'h077;
    localparam logic [15:0] RST_PLL_RSVD = 16'h0000;
    localparam logic [1:0] RST_SWING = 2'h0;
    localparam logic [15:0] RST_HYB_RSVD = 16'h9F22;
    localparam logic [1:0] RST_MODE = 2'h2;
    localparam logic [7:0] RST_LFSR = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_LOCK = 0;
    localparam int BIT_LOCK_CLEAR = 1;
    localparam int BIT_BYTE_OVF = 9;
    localparam int BIT_PKT_OVF = 10;
    localparam int BIT_FORCE_VAL = 9;
    localparam int BIT_FORCE_CTRL = 8;
    localparam int TX_DLY_LSB = 4;
    localparam int SWING_LSB = 13;
    localparam int BIT_COUNT_MODE = 0;
    localparam int BIT_SHIFT_MODE = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // delay-line code meaning and gap scaling
    localparam int DELAY_STEP_PS = 250;
    localparam logic [3:0] ALIGN_CODE = 4'hF;
    localparam logic [3:0] DEFAULT_CODE = 4'h7;
    localparam logic [3:0] MIN_SHIFT_CODE = 4'h3;
    localparam logic [3:0] MAX_SHIFT_CODE = 4'hD;
    localparam int GAP_UNIT_BYTES = 4;

    typedef enum logic [1:0] {
        PDC_GEN_IDLE = 2'b00,
        PDC_GEN_PKT = 2'b01,
        PDC_GEN_GAP = 2'b10
    } pdc_gen_state_t;

endpackage

// [src/pdc_gen_if.sv]
// carrier between the register slice and the test packet generator
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface pdc_gen_if;
    logic run;
    logic [15:0] pkt_bytes;
    logic [7:0] gap_words;
    logic ready;
    logic valid;
    logic last;
    logic [7:0] data;

    modport ctrl (output run, output pkt_bytes, output gap_words, output ready,
                  input valid, input last, input data);
    modport gen (input run, input pkt_bytes, input gap_words, input ready,
                 output valid, output last, output data);
endinterface

// [src/pdc_test_gen.sv]
// pseudo-random test packet generator: packets of programmed length, then a gap
// assumes one byte per cycle on the stream; gap counted in byte times
`timescale 1ns/1ps
module pdc_test_gen
    import pdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    pdc_gen_if.gen gif
);

    typedef struct packed {
        pdc_gen_state_t state;
        logic [15:0] byte_cnt;
        logic [9:0] gap_cnt;
        logic [7:0] lfsr;
    } pdc_gen_regs_t;

    pdc_gen_regs_t r_q;
    pdc_gen_regs_t r_d;

    ////////////////////////////////////////////////////////////////////////////////
    // handshake outputs are decoded from state, data comes straight from the lfsr flop
    assign gif.valid = (r_q.state == PDC_GEN_PKT);
    assign gif.last = gif.valid && (r_q.byte_cnt == gif.pkt_bytes - 16'h0001);
    assign gif.data = r_q.lfsr;

    // next state; a zero length is treated as "no packets" to avoid a runaway packet
    always_comb begin
        r_d = r_q;
        case (r_q.state)
            PDC_GEN_IDLE: begin
                if (gif.run && gif.pkt_bytes != 16'h0000) begin
                    r_d.state = PDC_GEN_PKT;
                    r_d.byte_cnt = 16'h0000;
                end
            end
            PDC_GEN_PKT: begin
                if (gif.ready) begin
                    r_d.lfsr = {r_q.lfsr[6:0],
                                r_q.lfsr[7] ^ r_q.lfsr[5] ^ r_q.lfsr[4] ^ r_q.lfsr[3]};
                    r_d.byte_cnt = r_q.byte_cnt + 16'h0001;
                    if (gif.last) begin
                        // gap of gap_words times four byte times
                        r_d.gap_cnt = 10'(gif.gap_words) * 10'(GAP_UNIT_BYTES); // R8
                        r_d.state = (gif.gap_words == 8'h00) ? PDC_GEN_IDLE : PDC_GEN_GAP;
                    end
                end
            end
            PDC_GEN_GAP: begin
                r_d.gap_cnt = r_q.gap_cnt - 10'h001;
                if (r_q.gap_cnt == 10'h001) begin
                    r_d.state = PDC_GEN_IDLE;
                end
            end
            default: begin
                r_d.state = PDC_GEN_IDLE;
            end
        endcase
        if (r_d.state == PDC_GEN_IDLE && gif.run && gif.pkt_bytes != 16'h0000
            && r_q.state != PDC_GEN_IDLE) begin
            r_d.state = PDC_GEN_PKT; // R7
            r_d.byte_cnt = 16'h0000;
        end
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r_q <= '{state: PDC_GEN_IDLE, byte_cnt: 16'h0000, gap_cnt: 10'h000, lfsr: RST_LFSR};
        end else begin
            r_q <= r_d;
        end
    end

endmodule // pdc_test_gen

// [src/pdc_top.sv]
// test counters, test generator settings and clock delay-line controls on wishbone
// assumes a classic wishbone master on sys_clk and checker events one cycle wide
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps

// What this block does
// [R1] A packet-counter overflow sets a sticky flag that only the clear strobe removes.
// [R2] A byte-counter overflow sets a sticky flag that only the clear strobe removes.
// [R3] Errored bytes seen by the checker are counted in 8 bits and read in the low byte.
// [R4] With counting mode zero the errored-byte count holds at its maximum instead of wrapping.
// [R5] Writing bit zero of the error count register freezes the counter values shown to reads.
// [R6] Writing bit one freezes the shown values, then zeroes the counters and overflow flags.
// [R7] Generated test packets are as long in bytes as the 16-bit length field, 1500 at reset.
// [R8] The gap between test packets is the 8-bit gap field times four bytes, 125 at reset.
// [R9] With force-control set the delay-line enable follows the force-value bit.
// [R10] The transmit delay takes a 4-bit code in 250 ps steps, code 7 at reset, as on receive.
// [R11] Odd codes 3 to D shift by 1.0 to 3.5 ns in half steps, code F is zero-delay align.
// [R12] The effective delay also depends on the shift-mode bit, bit one of the mode register.
// [R13] Software writes only swing codes zero to two; code three is never written.
module pdc_top
    import pdc_pkg::*;
(
    // clock, reset
    input wire logic sys_clk,
    input wire logic reset,

    // bus
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,

    // generator
    input wire logic gen_run,
    input wire logic gen_ready,
    output logic gen_valid,
    output logic gen_last,
    output logic [7:0] gen_data,

    // checker
    input wire logic chk_byte_valid,
    input wire logic chk_byte_error,
    input wire logic chk_packet_done,

    // delay line
    input wire logic dll_enable_internal,
    output logic dll_enable,
    output logic [DLY_W-1:0] tx_delay_ps,
    output logic tx_align,
    output logic [DLY_W-1:0] rx_delay_ps,
    output logic rx_align,
    output logic [1:0] serial_swing_select
);

    typedef struct packed {
        // bus
        logic ack;
        logic [REG_W-1:0] rdat;

        // counts
        logic [7:0] err_cnt;
        logic [15:0] byte_cnt;
        logic [15:0] pkt_cnt;

        // snapshots
        logic [7:0] err_snap;
        logic [15:0] byte_snap;
        logic [15:0] pkt_snap;

        // flags
        logic packet_counter_overflow;
        logic byte_counter_overflow;

        // fields
        logic [15:0] test_packet_bytes;
        logic [7:0] test_gap_words;
        logic [9:0] dll_ctrl;
        logic [15:0] pll_rsvd;
        logic [1:0] serial_swing_select;
        logic [15:0] hyb_rsvd;
        logic [1:0] mode;

        // outputs
        logic dll_en;
        logic [DLY_W:0] tx_dly;
        logic [DLY_W:0] rx_dly;
    } pdc_regs_t;

    pdc_regs_t r_q;
    pdc_regs_t r_d;

    pdc_gen_if gif ();

    ////////////////////////////////////////////////////////////////////////////////
    // delay code to {align, picoseconds}; unlisted codes, all even ones and code 1, fall back to the default
    function automatic logic [DLY_W:0] pdc_decode(input logic [3:0] code, input logic shift);
        logic [3:0] c;

        c = code;
        if (c != ALIGN_CODE && (!c[0] || c < MIN_SHIFT_CODE || c > MAX_SHIFT_CODE)) begin
            c = DEFAULT_CODE;
        end

        if (c == ALIGN_CODE || !shift) begin
            pdc_decode = {1'b1, {DLY_W{1'b0}}}; // R11 R12
        end else begin
            // code n gives (n+1) steps of 250 ps: 3 -> 1.0 ns, D -> 3.5 ns
            pdc_decode = {1'b0, DLY_W'((32'(c) + 32'd1) * 32'(DELAY_STEP_PS))}; // R11
        end
    endfunction

    // byte-lane merge for a 16-bit register in the low half of the bus word
    function automatic logic [15:0] pdc_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] sel);
        pdc_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // generator hookup
    assign gif.run = gen_run;
    assign gif.ready = gen_ready;
    assign gif.pkt_bytes = r_q.test_packet_bytes; // R7
    assign gif.gap_words = r_q.test_gap_words; // R8

    // stream back out
    assign gen_valid = gif.valid;
    assign gen_last = gif.last;
    assign gen_data = gif.data;

    pdc_test_gen i_pdc_test_gen (
        .sys_clk(sys_clk),
        .reset(reset),
        .gif(gif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign wb_ack = r_q.ack;
    assign wb_dat_r = {16'h0000, r_q.rdat};

    // delay-line and swing pins
    assign dll_enable = r_q.dll_en;
    assign tx_align = r_q.tx_dly[DLY_W];
    assign tx_delay_ps = r_q.tx_dly[DLY_W-1:0];
    assign rx_align = r_q.rx_dly[DLY_W];
    assign rx_delay_ps = r_q.rx_dly[DLY_W-1:0];
    assign serial_swing_select = r_q.serial_swing_select;

    // bus decode, counters and derived controls
    always_comb begin
        logic req;
        logic wr;
        logic [7:0] idx;
        logic [15:0] wd;
        logic lock;
        logic clr;
        logic sat;

        r_d = r_q;
        req = wb_cyc && wb_stb && !r_q.ack;
        wr = req && wb_we;
        idx = wb_adr[ADR_W-1:2];
        wd = wb_dat_w[15:0];

        // one-cycle strobes, and saturation from the counting-mode bit
        lock = 1'b0;
        clr = 1'b0;
        sat = !r_q.mode[BIT_COUNT_MODE];

        // one wait state: ack the cycle after the request, drop it the cycle after
        r_d.ack = req;

        // register writes; unmapped indices are acked and ignored
        if (wr) begin
            case (idx)
                IDX_ERR_CNT: begin
                    if (wb_sel[0]) begin
                        lock = wd[BIT_LOCK] | wd[BIT_LOCK_CLEAR]; // R5 R6
                        clr = wd[BIT_LOCK_CLEAR]; // R6
                    end
                end

                // stored settings
                IDX_PKT_LEN: r_d.test_packet_bytes = pdc_merge(r_q.test_packet_bytes, wd,
                                                               wb_sel[1:0]);
                IDX_GAP_LEN: begin
                    if (wb_sel[0]) begin
                        r_d.test_gap_words = wd[7:0];
                    end
                end
                IDX_DLL_CTRL: r_d.dll_ctrl = 10'(pdc_merge({6'h00, r_q.dll_ctrl}, wd,
                                                           wb_sel[1:0]));
                IDX_PLL_RSVD: r_d.pll_rsvd = pdc_merge(r_q.pll_rsvd, wd, wb_sel[1:0]);
                IDX_SWING: begin
                    // stored as written; code three is left to software to avoid
                    if (wb_sel[1]) begin
                        r_d.serial_swing_select = wd[SWING_LSB+1:SWING_LSB]; // R13
                    end
                end
                IDX_HYB_RSVD: r_d.hyb_rsvd = pdc_merge(r_q.hyb_rsvd, wd, wb_sel[1:0]);
                IDX_MODE: begin
                    if (wb_sel[0]) begin
                        r_d.mode = wd[1:0];
                    end
                end
                default: ;
            endcase
        end

        // lock copies the live counts before the clear zeroes them
        if (lock) begin
            r_d.err_snap = r_q.err_cnt; // R5
            r_d.byte_snap = r_q.byte_cnt;
            r_d.pkt_snap = r_q.pkt_cnt;
        end

        if (clr) begin
            r_d.err_cnt = 8'h00; // R6
            r_d.byte_cnt = 16'h0000;
            r_d.pkt_cnt = 16'h0000;
            r_d.packet_counter_overflow = 1'b0;
            r_d.byte_counter_overflow = 1'b0;
        end

        // live counting; an event in the clear cycle counts from zero, so none is lost
        // a flag set beats a clear in that cycle
        if (chk_byte_valid && chk_byte_error) begin
            if (!(sat && r_q.err_cnt == 8'hFF && !clr)) begin // R4
                r_d.err_cnt = r_d.err_cnt + 8'h01; // R3
            end
        end

        if (chk_byte_valid) begin
            if (r_q.byte_cnt == 16'hFFFF) begin
                r_d.byte_counter_overflow = 1'b1; // R2
                r_d.byte_cnt = (sat && !clr) ? 16'hFFFF : {15'h0000, clr};
            end else begin
                r_d.byte_cnt = r_d.byte_cnt + 16'h0001;
            end
        end

        if (chk_packet_done) begin
            if (r_q.pkt_cnt == 16'hFFFF) begin
                r_d.packet_counter_overflow = 1'b1; // R1
                r_d.pkt_cnt = (sat && !clr) ? 16'hFFFF : {15'h0000, clr};
            end else begin
                r_d.pkt_cnt = r_d.pkt_cnt + 16'h0001;
            end
        end

        // read data captured with the ack; counts show the frozen copies
        r_d.rdat = 16'h0000;

        if (req && !wb_we) begin
            case (idx)
                IDX_ERR_CNT: r_d.rdat = {5'h00, r_q.packet_counter_overflow,
                                         r_q.byte_counter_overflow, 1'b0, r_q.err_snap};
                IDX_PKT_LEN: r_d.rdat = r_q.test_packet_bytes;
                IDX_GAP_LEN: r_d.rdat = {8'h00, r_q.test_gap_words};
                IDX_DLL_CTRL: r_d.rdat = {6'h00, r_q.dll_ctrl};
                IDX_PLL_RSVD: r_d.rdat = r_q.pll_rsvd;
                IDX_SWING: r_d.rdat = {1'b0, r_q.serial_swing_select, 13'h0000};
                IDX_HYB_RSVD: r_d.rdat = r_q.hyb_rsvd;
                IDX_MODE: r_d.rdat = {14'h0000, r_q.mode};

                // snapshot registers
                IDX_BYTE_SNAP: r_d.rdat = r_q.byte_snap;
                IDX_PKT_SNAP: r_d.rdat = r_q.pkt_snap;
                default: r_d.rdat = 16'h0000;
            endcase
        end

        // delay-line controls follow the stored fields one cycle later
        r_d.dll_en = r_q.dll_ctrl[BIT_FORCE_CTRL] ? r_q.dll_ctrl[BIT_FORCE_VAL]
                                                  : dll_enable_internal; // R9

        r_d.tx_dly = pdc_decode(r_q.dll_ctrl[TX_DLY_LSB+3:TX_DLY_LSB],
                                r_q.mode[BIT_SHIFT_MODE]); // R10 R12
        r_d.rx_dly = pdc_decode(r_q.dll_ctrl[3:0], r_q.mode[BIT_SHIFT_MODE]); // R11 R12
    end

    ////////////////////////////////////////////////////////////////////////////////
    // single state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r_q <= '0;
            // defaults; counts start at zero
            r_q.test_packet_bytes <= RST_PKT_LEN; // R7
            r_q.test_gap_words <= RST_GAP_LEN; // R8
            r_q.dll_ctrl <= RST_DLL_CTRL; // R10
            r_q.pll_rsvd <= RST_PLL_RSVD;
            r_q.serial_swing_select <= RST_SWING;
            r_q.hyb_rsvd <= RST_HYB_RSVD;
            r_q.mode <= RST_MODE;
        end else begin
            r_q <= r_d;
        end
    end

endmodule // pdc_top

// [test/pdc_chk.sv]
// port-level assertions for the test-counter and delay-line register slice
// assumes it is bound into pdc_top and sees one clock with synchronous reset
`timescale 1ns/1ps
module pdc_chk
    import pdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic gen_ready,
    input wire logic gen_valid,
    input wire logic gen_last,
    input wire logic [7:0] gen_data,
    input wire logic [DLY_W-1:0] tx_delay_ps,
    input wire logic tx_align,
    input wire logic [DLY_W-1:0] rx_delay_ps,
    input wire logic rx_align
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////
    // steps of a bus request and of a packet end
    sequence seq_req;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence seq_last_taken;
        gen_valid && gen_last && gen_ready;
    endsequence

    ////////////////////////////////////////
    // a taken request is answered on the next edge, once only
    chk_ack_answer: assert property (seq_req |=> wb_ack) else $error("ack missing");
    chk_ack_single: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
    // unused bits of the error count register always read zero
    chk_err_reserved: assert property (wb_ack && !wb_we && wb_adr[9:2] == IDX_ERR_CNT
        |-> wb_dat_r[31:11] == '0 && !wb_dat_r[8]) else $error("err bits set");
    // align mode means zero delay; shift mode on rx only the six listed steps
    chk_rx_align: assert property (rx_align |-> rx_delay_ps == '0) else $error("rx align");
    chk_tx_align: assert property (tx_align |-> tx_delay_ps == '0) else $error("tx align");
    chk_rx_steps: assert property (!rx_align && !$past(reset) && !$past(reset, 2)
        |-> rx_delay_ps inside {1000, 1500, 2000, 2500, 3000, 3500})
        else $error("rx step");
    // a stalled byte stays offered and unchanged
    chk_gen_hold: assert property (gen_valid && !gen_ready |=> gen_valid && $stable(gen_data))
        else $error("byte dropped");
    chk_gen_gap: assert property (seq_last_taken |=> !gen_valid) else $error("no gap");
    chk_last_valid: assert property (gen_last |-> gen_valid) else $error("stray last");
endmodule // pdc_chk

bind pdc_top pdc_chk i_pdc_chk (.sys_clk(sys_clk), .reset(reset), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .gen_ready(gen_ready), .gen_valid(gen_valid), .gen_last(gen_last), .gen_data(gen_data),
    .tx_delay_ps(tx_delay_ps), .tx_align(tx_align), .rx_delay_ps(rx_delay_ps),
    .rx_align(rx_align));

// [test/tb.sv]
// self-checking bench for the register slice: bus, counters, generator, delays
// assumes pdc_top with a classic wishbone slave answering one cycle after taking
`timescale 1ns/1ps
module tb;
    import pdc_pkg::*;
    logic sys_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, gen_run, gen_ready, gen_valid;
    logic gen_last, chk_byte_valid, chk_byte_error, chk_packet_done, dll_enable_internal;
    logic dll_enable, tx_align, rx_align;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [7:0] gen_data;
    logic [DLY_W-1:0] tx_delay_ps, rx_delay_ps;
    logic [1:0] serial_swing_select;
    int num_errors, checked;

    pdc_top i_pdc_top (.sys_clk(sys_clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .gen_run(gen_run), .gen_ready(gen_ready),
        .gen_valid(gen_valid), .gen_last(gen_last), .gen_data(gen_data),
        .chk_byte_valid(chk_byte_valid), .chk_byte_error(chk_byte_error),
        .chk_packet_done(chk_packet_done), .dll_enable_internal(dll_enable_internal),
        .dll_enable(dll_enable), .tx_delay_ps(tx_delay_ps), .tx_align(tx_align),
        .rx_delay_ps(rx_delay_ps), .rx_align(rx_align),
        .serial_swing_select(serial_swing_select));

    ////////////////////////////////////////
    // clock, compare, bus and event helpers
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // entered just after an edge; holds the request until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] wd,
                       output logic [15:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'h0};
        wb_dat_w <= {16'h0000, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        if (n >= 40) cmp("bus ack", 32'h1, 32'h0);
        rd = wb_dat_r[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rdc(input string what, input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] x;
        bus(1'b0, idx, 16'h0000, x);
        cmp(what, {16'h0000, exp}, {16'h0000, x});
    endtask
    // n back-to-back checked bytes, optionally errored and with packet ends
    task automatic ev(input int n, input logic err, input logic pkt);
        chk_byte_valid <= 1'b1;
        chk_byte_error <= err;
        chk_packet_done <= pkt;
        repeat (n) @(posedge sys_clk);
        chk_byte_valid <= 1'b0;
        chk_packet_done <= 1'b0;
        @(posedge sys_clk);
    endtask
    // expected {align, delay} for one delay code with shift mode on
    function automatic logic [12:0] dly(input logic [3:0] c);
        if (c == 4'hF) return 13'h1000;
        if (c[0] && c >= 4'h3 && c <= 4'hD) return {1'b0, 12'((c + 1) * 250)};
        return 13'h07D0;
    endfunction

    ////////////////////////////////////////
    // scenarios
    task automatic t_reset_values();
        rdc("err cnt", IDX_ERR_CNT, 16'h0000);
        rdc("pkt len", IDX_PKT_LEN, 16'h05DC);
        rdc("gap len", IDX_GAP_LEN, 16'h007D);
        rdc("dll ctrl", IDX_DLL_CTRL, 16'h0077);
        rdc("pll", IDX_PLL_RSVD, 16'h0000);
        rdc("swing", IDX_SWING, 16'h0000);
        rdc("hybrid", IDX_HYB_RSVD, 16'h9F22);
        rdc("mode", IDX_MODE, 16'h0002);
        rdc("unmapped", 8'h10, 16'h0000);
        cmp("tx reset", 32'h07D0, {19'h0, tx_align, tx_delay_ps});
    endtask
    task automatic t_regs_rw();
        wr(IDX_PKT_LEN, 16'h1234);
        rdc("pkt len", IDX_PKT_LEN, 16'h1234);
        wr(IDX_GAP_LEN, 16'hFFFF);
        rdc("gap len", IDX_GAP_LEN, 16'h00FF);
        wr(IDX_DLL_CTRL, 16'hFFFF);
        rdc("dll ctrl", IDX_DLL_CTRL, 16'h03FF);
        wr(IDX_PLL_RSVD, 16'hA5C3);
        rdc("pll", IDX_PLL_RSVD, 16'hA5C3);
        for (int c = 2; c >= 0; c--) begin
            wr(IDX_SWING, {1'b0, 2'(c), 13'h0000});
            cmp("swing pin", 32'(c), {30'h0, serial_swing_select});
        end
    endtask
    task automatic t_delay();
        for (int c = 0; c < 16; c++) begin
            wr(IDX_DLL_CTRL, {8'h00, 4'(15 - c), 4'(c)});
            repeat (2) @(posedge sys_clk);
            cmp("rx delay", {19'h0, dly(4'(c))}, {19'h0, rx_align, rx_delay_ps});
            cmp("tx delay", {19'h0, dly(4'(15 - c))}, {19'h0, tx_align, tx_delay_ps});
        end
        wr(IDX_MODE, 16'h0000);
        repeat (2) @(posedge sys_clk);
        cmp("no shift", 32'h1000, {19'h0, rx_align, rx_delay_ps});
        wr(IDX_MODE, 16'h0002);
        wr(IDX_DLL_CTRL, 16'h0077);
    endtask
    task automatic t_force();
        dll_enable_internal <= 1'b1;
        wr(IDX_DLL_CTRL, 16'h0177);
        cmp("forced low", 32'h0, {31'h0, dll_enable});
        dll_enable_internal <= 1'b0;
        wr(IDX_DLL_CTRL, 16'h0377);
        cmp("forced high", 32'h1, {31'h0, dll_enable});
        wr(IDX_DLL_CTRL, 16'h0277);
        cmp("follows", 32'h0, {31'h0, dll_enable});
    endtask
    task automatic t_errors();
        wr(IDX_ERR_CNT, 16'h0002);
        ev(3, 1'b0, 1'b0);
        ev(5, 1'b1, 1'b0);
        wr(IDX_ERR_CNT, 16'h0001);
        rdc("err count", IDX_ERR_CNT, 16'h0005);
        ev(2, 1'b1, 1'b0);
        rdc("frozen", IDX_ERR_CNT, 16'h0005);
        ev(300, 1'b1, 1'b0);
        wr(IDX_ERR_CNT, 16'h0001);
        rdc("saturate", IDX_ERR_CNT, 16'h00FF);
        wr(IDX_MODE, 16'h0003);
        wr(IDX_ERR_CNT, 16'h0002);
        ev(258, 1'b1, 1'b0);
        wr(IDX_ERR_CNT, 16'h0001);
        rdc("wrap", IDX_ERR_CNT, 16'h0002);
        rdc("bytes", IDX_BYTE_SNAP, 16'h0102);
        wr(IDX_MODE, 16'h0002);
    endtask
    task automatic t_overflow();
        wr(IDX_ERR_CNT, 16'h0002);
        ev(65536, 1'b0, 1'b1);
        wr(IDX_ERR_CNT, 16'h0001);
        rdc("both ovf", IDX_ERR_CNT, 16'h0600);
        rdc("byte hold", IDX_BYTE_SNAP, 16'hFFFF);
        rdc("pkt hold", IDX_PKT_SNAP, 16'hFFFF);
        ev(1, 1'b0, 1'b0);
        wr(IDX_ERR_CNT, 16'h0001);
        rdc("sticky", IDX_ERR_CNT, 16'h0600);
        wr(IDX_ERR_CNT, 16'h0002);
        rdc("cleared", IDX_ERR_CNT, 16'h0000);
    endtask
    // ready toggles every cycle so each byte after the first is stalled once
    task automatic t_gen();
        int n, nb, low, pkts;
        n = 0;
        nb = 0;
        low = 0;
        pkts = 0;
        wr(IDX_PKT_LEN, 16'h0005);
        wr(IDX_GAP_LEN, 16'h0002);
        gen_run <= 1'b1;
        while (pkts < 2 && n < 200) begin
            @(posedge sys_clk);
            n++;
            if (gen_valid === 1'b1 && gen_ready === 1'b1) begin
                if (pkts == 0 && nb == 0) cmp("first byte", 32'hFF, {24'h0, gen_data});
                nb++;
                if (gen_last === 1'b1) begin
                    cmp("pkt bytes", 32'h5, nb);
                    nb = 0;
                    pkts++;
                end
            end else if (gen_valid === 1'b0 && pkts == 1 && nb == 0) begin
                low++;
            end
            gen_ready <= ~gen_ready;
        end
        cmp("packets", 32'h2, pkts);
        cmp("gap cycles", 32'(2 * GAP_UNIT_BYTES), low);
        gen_run <= 1'b0;
    endtask

    ////////////////////////////////////////
    // verdict, watchdog and main sequence
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        {wb_cyc, wb_stb, wb_we, gen_run, gen_ready} = 5'h00;
        {chk_byte_valid, chk_byte_error, chk_packet_done, dll_enable_internal} = 4'h0;
        wb_adr = '0;
        wb_sel = 4'h3;
        wb_dat_w = 32'h0000_0000;
        num_errors = 0;
        checked = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset_values();
        t_regs_rw();
        t_delay();
        t_force();
        t_errors();
        t_overflow();
        t_gen();
        wrap_up();
    end
endmodule // tb
